// ---- common/shb_consts.svh ----
`ifndef SHB_CONSTS_SVH
`define SHB_CONSTS_SVH
// ****************************************
// configuration port map and keys
// ****************************************
`define SHB_CFG_INDEX_PORT 16'h004E
`define SHB_CFG_DATA_PORT 16'h004F
`define SHB_KEY_ENTER 8'h55
`define SHB_KEY_EXIT 8'hAA
`define SHB_IDX_LDN 8'h07
`define SHB_IDX_MODE 8'hF0
`define SHB_LDN_CH_A 8'h04
`define SHB_LDN_CH_B 8'h05
`define SHB_MODE_HS_BIT 1
// ****************************************
// serial channel register map
// ****************************************
`define SHB_UART_BASE_A 16'h03E8
`define SHB_UART_BASE_B 16'h02E8
`define SHB_OFS_DIV_LO 3'h0
`define SHB_OFS_DIV_HI 3'h1
`define SHB_OFS_LCR 3'h3
`define SHB_LCR_LATCH_BIT 7
`define SHB_LCR_EIGHT_NONE_ONE 8'h03
`define SHB_DIV_HS_SLOW 16'h8002
`define SHB_DIV_HS_FAST 16'h8001
// ****************************************
// reset values
// ****************************************
`define SHB_RST_BYTE 8'h00
`define SHB_RST_DIV 16'h0000
`define SHB_UNMAPPED_READ 8'hFF
// ****************************************
// rates and clock
// ****************************************
`define SHB_BAUD_HS_SLOW 230400
`define SHB_BAUD_HS_FAST 460800
`define SHB_OVERSAMPLE 16
`define SHB_CLK_HZ 25000000
`define SHB_NORMAL_PRESCALE_MAX 2'h3
`endif

// ---- common/shb_pkg.sv ----
package shb_pkg;
    // character format handed to the serial channel, low lcr bits in order
    typedef struct packed {
        logic break_ctl;
        logic stick_par;
        logic even_par;
        logic parity_en;
        logic two_stop;
        logic [1:0] word_len;
    } shb_fmt_type;

    typedef enum {
        SHB_RUN_MODE,
        SHB_CFG_MODE
    } shb_cfg_state_type;
endpackage

// ---- hdl/shb_high_speed_cfg.sv ----
`include "shb_consts.svh"
module shb_high_speed_cfg #(
    parameter int ACC_W = 24
) (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    // host byte-wide i/o port
    input wire logic [15:0] IO_ADDR,
    input wire logic [7:0] IO_WDATA,
    input wire logic IO_WR,
    input wire logic IO_RD,
    output logic [7:0] IO_RDATA,
    output logic IO_RACK,
    // serial channel controls, index 0 is channel a
    output logic [1:0] BAUD16X_TICK,
    output logic [1:0] HS_ACTIVE,
    output shb_pkg::shb_fmt_type [1:0] LINE_FMT,
    output logic CFG_MODE
);
    // ****************************************
    // elaboration checks and constants
    // ****************************************
    // the fast reference is the 16x clock of the top rate; normal rates run a quarter of it
    localparam logic [63:0] FAST_REF_HZ = 64'(`SHB_BAUD_HS_FAST) * 64'(`SHB_OVERSAMPLE);
    localparam logic [63:0] ACC_INC64 = (FAST_REF_HZ << ACC_W) / 64'(`SHB_CLK_HZ);
    localparam logic [ACC_W-1:0] ACC_INC = ACC_INC64[ACC_W-1:0];
    localparam logic [15:0] UART_BASE [2] = '{`SHB_UART_BASE_A, `SHB_UART_BASE_B};
    localparam logic [7:0] LDN_CODE [2] = '{`SHB_LDN_CH_A, `SHB_LDN_CH_B};

    generate
        if (ACC_W < 16 || ACC_W > 32) begin : g_bad_acc
            $error("accumulator width out of range");
        end
    endgenerate

    function automatic logic chan_hit(input logic [15:0] addr, input logic [15:0] base);
        return addr[15:3] == base[15:3];
    endfunction

    // ****************************************
    // configuration access
    // ****************************************
    shb_pkg::shb_cfg_state_type state_q;
    logic [7:0] index_q;
    logic [7:0] ldn_q;
    logic [7:0] mode_q [2];
    logic cfg_on;
    logic wr_idx;
    logic wr_dat;
    logic rd_idx;
    logic rd_dat;

    assign cfg_on = (state_q == shb_pkg::SHB_CFG_MODE);
    assign wr_idx = IO_WR && (IO_ADDR == `SHB_CFG_INDEX_PORT);
    assign wr_dat = IO_WR && (IO_ADDR == `SHB_CFG_DATA_PORT);
    assign rd_idx = IO_RD && (IO_ADDR == `SHB_CFG_INDEX_PORT);
    assign rd_dat = IO_RD && (IO_ADDR == `SHB_CFG_DATA_PORT);

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            state_q <= shb_pkg::SHB_RUN_MODE;
        end else if (wr_idx) begin
            case (state_q)
                shb_pkg::SHB_RUN_MODE: begin
                    if (IO_WDATA == `SHB_KEY_ENTER) begin
                        state_q <= shb_pkg::SHB_CFG_MODE;
                    end
                end
                shb_pkg::SHB_CFG_MODE: begin
                    if (IO_WDATA == `SHB_KEY_EXIT) begin
                        state_q <= shb_pkg::SHB_RUN_MODE;
                    end
                end
                default: begin
                    state_q <= shb_pkg::SHB_RUN_MODE;
                end
            endcase
        end
    end

    // the exit key is not taken as an index, so the pointer survives a lock
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            index_q <= `SHB_RST_BYTE;
        end else if (wr_idx && cfg_on && IO_WDATA != `SHB_KEY_EXIT) begin
            index_q <= IO_WDATA;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            ldn_q <= `SHB_RST_BYTE;
        end else if (wr_dat && cfg_on && index_q == `SHB_IDX_LDN) begin
            ldn_q <= IO_WDATA;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            CFG_MODE <= 1'b0;
        end else begin
            CFG_MODE <= cfg_on;
        end
    end

    // ****************************************
    // shared rate reference
    // ****************************************
    logic [ACC_W-1:0] acc_q;
    logic [ACC_W:0] acc_sum;
    logic [1:0] pre_q;
    logic fast_tick_q;
    logic base_tick_q;

    assign acc_sum = {1'b0, acc_q} + {1'b0, ACC_INC};

    // phase accumulation keeps the long-run rate exact at the cost of tick jitter
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            acc_q <= '0;
            fast_tick_q <= 1'b0;
        end else begin
            acc_q <= acc_sum[ACC_W-1:0];
            fast_tick_q <= acc_sum[ACC_W];
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            pre_q <= 2'h0;
            base_tick_q <= 1'b0;
        end else begin
            base_tick_q <= acc_sum[ACC_W] && (pre_q == `SHB_NORMAL_PRESCALE_MAX);
            if (acc_sum[ACC_W]) begin
                pre_q <= pre_q + 2'h1;
            end
        end
    end

    // ****************************************
    // serial channels
    // ****************************************
    logic [15:0] div_q [2];
    logic [7:0] lcr_q [2];
    logic [15:0] cnt_q [2];
    logic [1:0] hs_eff;
    logic [1:0] ch_tick_q;

    for (genvar g = 0; g < 2; g++) begin : g_ch
        logic uwr;
        logic latch_open;
        logic div_wr;
        logic [15:0] eff_div;
        logic src_tick;

        assign uwr = IO_WR && chan_hit(IO_ADDR, UART_BASE[g]);
        assign latch_open = lcr_q[g][`SHB_LCR_LATCH_BIT];
        assign div_wr = uwr && latch_open && (IO_ADDR[2:0] == `SHB_OFS_DIV_LO || IO_ADDR[2:0] == `SHB_OFS_DIV_HI);
        // both the mode bit and divisor bit 15 are needed for the fast mapping
        assign hs_eff[g] = mode_q[g][`SHB_MODE_HS_BIT] && div_q[g][15];
        assign eff_div = hs_eff[g] ? {1'b0, div_q[g][14:0]} : div_q[g];
        assign src_tick = hs_eff[g] ? fast_tick_q : base_tick_q;

        always_ff @(posedge REF_CLK) begin
            if (RST) begin
                mode_q[g] <= `SHB_RST_BYTE;
            end else if (wr_dat && cfg_on && index_q == `SHB_IDX_MODE && ldn_q == LDN_CODE[g]) begin
                mode_q[g] <= IO_WDATA;
            end
        end

        always_ff @(posedge REF_CLK) begin
            if (RST) begin
                div_q[g] <= `SHB_RST_DIV;
            end else if (div_wr && IO_ADDR[2:0] == `SHB_OFS_DIV_LO) begin
                div_q[g][7:0] <= IO_WDATA;
            end else if (div_wr) begin
                div_q[g][15:8] <= IO_WDATA;
            end
        end

        always_ff @(posedge REF_CLK) begin
            if (RST) begin
                lcr_q[g] <= `SHB_RST_BYTE;
            end else if (uwr && IO_ADDR[2:0] == `SHB_OFS_LCR) begin
                lcr_q[g] <= IO_WDATA;
            end
        end

        // divisor zero stops the ticks; a divisor write restarts the count
        always_ff @(posedge REF_CLK) begin
            if (RST) begin
                cnt_q[g] <= 16'h0000;
                ch_tick_q[g] <= 1'b0;
            end else if (div_wr) begin
                cnt_q[g] <= 16'h0000;
                ch_tick_q[g] <= 1'b0;
            end else begin
                ch_tick_q[g] <= src_tick && cnt_q[g] == 16'h0000 && eff_div != 16'h0000;
                if (src_tick && eff_div != 16'h0000) begin
                    cnt_q[g] <= (cnt_q[g] == 16'h0000) ? eff_div - 16'h0001 : cnt_q[g] - 16'h0001;
                end
            end
        end

        always_ff @(posedge REF_CLK) begin
            if (RST) begin
                BAUD16X_TICK[g] <= 1'b0;
                HS_ACTIVE[g] <= 1'b0;
                LINE_FMT[g] <= '0;
            end else begin
                BAUD16X_TICK[g] <= ch_tick_q[g];
                HS_ACTIVE[g] <= hs_eff[g];
                LINE_FMT[g] <= shb_pkg::shb_fmt_type'(lcr_q[g][6:0]);
            end
        end
    end

    // ****************************************
    // read path
    // ****************************************
    logic [7:0] cfg_val;
    logic [7:0] rd_val;

    always_comb begin
        cfg_val = `SHB_RST_BYTE;
        case (index_q)
            `SHB_IDX_LDN: cfg_val = ldn_q;
            `SHB_IDX_MODE: begin
                for (int c = 0; c < 2; c++) begin
                    if (ldn_q == LDN_CODE[c]) begin
                        cfg_val = mode_q[c];
                    end
                end
            end
            default: cfg_val = `SHB_RST_BYTE;
        endcase
    end

    // locked configuration ports and unowned addresses float high
    always_comb begin
        rd_val = `SHB_UNMAPPED_READ;
        if (rd_idx && cfg_on) begin
            rd_val = index_q;
        end else if (rd_dat && cfg_on) begin
            rd_val = cfg_val;
        end
        for (int c = 0; c < 2; c++) begin
            if (chan_hit(IO_ADDR, UART_BASE[c])) begin
                if (IO_ADDR[2:0] == `SHB_OFS_LCR) begin
                    rd_val = lcr_q[c];
                end else if (IO_ADDR[2:0] == `SHB_OFS_DIV_LO && lcr_q[c][`SHB_LCR_LATCH_BIT]) begin
                    rd_val = div_q[c][7:0];
                end else if (IO_ADDR[2:0] == `SHB_OFS_DIV_HI && lcr_q[c][`SHB_LCR_LATCH_BIT]) begin
                    rd_val = div_q[c][15:8];
                end
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            IO_RDATA <= `SHB_UNMAPPED_READ;
            IO_RACK <= 1'b0;
        end else begin
            IO_RACK <= IO_RD;
            if (IO_RD) begin
                IO_RDATA <= rd_val;
            end
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);

    key_enter_a: assert property (!cfg_on && wr_idx && IO_WDATA == `SHB_KEY_ENTER |=> cfg_on && CFG_MODE == 1'b0 ##1 CFG_MODE)
        else $error("enter key did not open configuration");
    key_exit_a: assert property (cfg_on && wr_idx && IO_WDATA == `SHB_KEY_EXIT |=> !cfg_on && index_q == $past(index_q))
        else $error("exit key did not lock configuration");
    ldn_write_a: assert property (cfg_on && wr_dat && index_q == `SHB_IDX_LDN |=> ldn_q == $past(IO_WDATA))
        else $error("device select not written");
    mode_write_a: assert property (cfg_on && wr_dat && index_q == `SHB_IDX_MODE && ldn_q == `SHB_LDN_CH_B
        |=> mode_q[1] == $past(IO_WDATA) && $stable(mode_q[0]))
        else $error("mode register write misrouted");
    locked_hold_a: assert property (!cfg_on && wr_dat |=> $stable(ldn_q) && $stable(mode_q[0]) && $stable(mode_q[1]))
        else $error("locked configuration changed");
    read_back_a: assert property (cfg_on && rd_dat && index_q == `SHB_IDX_MODE && ldn_q == `SHB_LDN_CH_A
        |=> IO_RACK && IO_RDATA == $past(mode_q[0]))
        else $error("mode register read back wrong");
    index_read_a: assert property (cfg_on && rd_idx && !wr_idx |=> IO_RDATA == $past(index_q))
        else $error("index port read wrong");
    latch_write_a: assert property (wr_idx == 1'b0 && IO_WR && IO_ADDR == `SHB_UART_BASE_A && lcr_q[0][7]
        |=> div_q[0][7:0] == $past(IO_WDATA))
        else $error("divisor low byte not latched");
    hs_flag_a: assert property (mode_q[0][`SHB_MODE_HS_BIT] && div_q[0][15] |=> HS_ACTIVE[0])
        else $error("high-speed not flagged");
    // a rewrite of the same divisor restarts the count, so writes are left out
    fast_rate_a: assert property (hs_eff[0] && div_q[0] == `SHB_DIV_HS_FAST && $stable(div_q[0]) && fast_tick_q
        && !IO_WR |=> ch_tick_q[0])
        else $error("fast rate missed a reference tick");
    // a divisor rewrite inside the gap restarts the count and may tick early
    slow_rate_a: assert property (hs_eff[1] && div_q[1] == `SHB_DIV_HS_SLOW && ch_tick_q[1]
        |=> (!ch_tick_q[1] || div_q[1] != `SHB_DIV_HS_SLOW) [*5])
        else $error("slow high rate ticks too close");
    // the tick that leaves the fast source on a mode change is not yet spaced
    normal_rate_a: assert property (!mode_q[0][`SHB_MODE_HS_BIT] && div_q[0][15] && ch_tick_q[0]
        && $stable(mode_q[0]) |=> !ch_tick_q[0] [*8])
        else $error("ordinary divisor ran fast");
    fmt_map_a: assert property (lcr_q[1] == `SHB_LCR_EIGHT_NONE_ONE ##1 lcr_q[1] == `SHB_LCR_EIGHT_NONE_ONE
        |-> LINE_FMT[1].word_len == 2'h3 && !LINE_FMT[1].parity_en && !LINE_FMT[1].two_stop)
        else $error("line format decode wrong");

    cfg_entry_c: cover property (!cfg_on ##1 cfg_on ##[1:20] !cfg_on);
    hs_both_c: cover property (HS_ACTIVE == 2'h3);
    fast_tick_c: cover property (hs_eff[0] && div_q[0] == `SHB_DIV_HS_FAST && BAUD16X_TICK[0]);
    slow_tick_c: cover property (hs_eff[1] && div_q[1] == `SHB_DIV_HS_SLOW && BAUD16X_TICK[1]);
endmodule

// ---- test/serial_high_speed_baud_config_tb_top.sv ----
`include "shb_consts.svh"
module serial_high_speed_baud_config_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // signals and bench state
    // ****************************************
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] io_addr = 16'h0000;
    logic [7:0] io_wdata = 8'h00;
    logic io_wr = 1'b0;
    logic io_rd = 1'b0;
    logic [7:0] io_rdata;
    logic io_rack;
    logic [1:0] baud16x_tick;
    logic [1:0] hs_active;
    shb_pkg::shb_fmt_type [1:0] line_fmt;
    logic cfg_mode;
    int miscompares = 0;
    int compares = 0;
    int tick_cnt[2];
    logic [7:0] exp_q[$];
    logic [31:0] rng = 32'hF25DAF0E;
    logic [7:0] mode_v[2];
    logic [15:0] base[2] = '{`SHB_UART_BASE_A, `SHB_UART_BASE_B};
    logic [15:0] div[2] = '{`SHB_DIV_HS_FAST, `SHB_DIV_HS_SLOW};
    logic [7:0] ldn[2] = '{`SHB_LDN_CH_A, `SHB_LDN_CH_B};
    // 2000 cycles at 25 MHz against a 7.3728 MHz fast reference
    int fast_n = 2000 * 73728 / 250000;

    always #20 ref_clk = ~ref_clk;

    shb_high_speed_cfg uut (
        .REF_CLK(ref_clk),
        .RST(rst),
        .IO_ADDR(io_addr),
        .IO_WDATA(io_wdata),
        .IO_WR(io_wr),
        .IO_RD(io_rd),
        .IO_RDATA(io_rdata),
        .IO_RACK(io_rack),
        .BAUD16X_TICK(baud16x_tick),
        .HS_ACTIVE(hs_active),
        .LINE_FMT(line_fmt),
        .CFG_MODE(cfg_mode)
    );
    // ****************************************
    // helpers
    // ****************************************
    function logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction

    task wrap_up;
        if (miscompares == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            miscompares++;
        end
    endtask

    task in_range(input int got, input int lo, input int hi);
        compares++;
        if (got < lo || got > hi) begin
            $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
            miscompares++;
        end
    endtask

    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(posedge ref_clk);
        #1;
        io_wr = 1'b0;
    endtask

    // the expected byte is noted before the strobe, the monitor consumes it
    task rd(input logic [15:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge ref_clk);
        #1;
        io_addr = a;
        io_rd = 1'b1;
        @(posedge ref_clk);
        #1;
        io_rd = 1'b0;
    endtask

    task count_ticks;
        tick_cnt[0] = 0;
        tick_cnt[1] = 0;
        repeat (2000) @(posedge ref_clk);
        #1;
    endtask

    task settle;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask
    // ****************************************
    // output watchers
    // ****************************************
    always @(posedge ref_clk) begin
        if (io_rack === 1'b1) begin
            if (exp_q.size() == 0) begin
                $display("[FAIL] t=%0t got=%h exp=%h", $time, io_rdata, 8'h00);
                miscompares++;
            end else begin
                chk(16'(io_rdata), 16'(exp_q.pop_front()));
            end
        end
        for (int i = 0; i < 2; i++) begin
            if (baud16x_tick[i] === 1'b1)
                tick_cnt[i]++;
        end
    end

    initial begin
        repeat (30000) @(posedge ref_clk);
        miscompares++;
        wrap_up;
    end
    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        repeat (20) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        rd(`SHB_CFG_INDEX_PORT, `SHB_UNMAPPED_READ);
        wr(`SHB_CFG_INDEX_PORT, `SHB_KEY_EXIT);
        wr(`SHB_CFG_DATA_PORT, 8'h5A);
        settle;
        chk(16'(cfg_mode), 16'h0000);
        wr(`SHB_CFG_INDEX_PORT, `SHB_KEY_ENTER);
        settle;
        chk(16'(cfg_mode), 16'h0001);
        for (int ch = 0; ch < 2; ch++) begin
            wr(`SHB_CFG_INDEX_PORT, `SHB_IDX_LDN);
            wr(`SHB_CFG_DATA_PORT, ldn[ch]);
            rd(`SHB_CFG_DATA_PORT, ldn[ch]);
            wr(`SHB_CFG_INDEX_PORT, `SHB_IDX_MODE);
            rd(`SHB_CFG_INDEX_PORT, `SHB_IDX_MODE);
            rd(`SHB_CFG_DATA_PORT, `SHB_RST_BYTE);
            rng = xorshift(rng);
            mode_v[ch] = rng[7:0] | 8'h02;
            wr(`SHB_CFG_DATA_PORT, mode_v[ch]);
            rd(`SHB_CFG_DATA_PORT, mode_v[ch]);
        end
        // a device code that owns no mode register takes no mode write
        wr(`SHB_CFG_INDEX_PORT, `SHB_IDX_LDN);
        wr(`SHB_CFG_DATA_PORT, 8'h06);
        wr(`SHB_CFG_INDEX_PORT, `SHB_IDX_MODE);
        wr(`SHB_CFG_DATA_PORT, 8'hFF);
        rd(`SHB_CFG_DATA_PORT, 8'h00);
        wr(`SHB_CFG_INDEX_PORT, `SHB_KEY_EXIT);
        settle;
        chk(16'(cfg_mode), 16'h0000);
        rd(`SHB_CFG_DATA_PORT, `SHB_UNMAPPED_READ);
        for (int ch = 0; ch < 2; ch++) begin
            wr(base[ch] + 16'h0003, 8'h80);
            rd(base[ch] + 16'h0003, 8'h80);
            wr(base[ch], div[ch][7:0]);
            wr(base[ch] + 16'h0001, div[ch][15:8]);
            rd(base[ch], div[ch][7:0]);
            rd(base[ch] + 16'h0001, div[ch][15:8]);
            wr(base[ch] + 16'h0003, `SHB_LCR_EIGHT_NONE_ONE);
            rd(base[ch], `SHB_UNMAPPED_READ);
            settle;
            chk(16'(line_fmt[ch]), 16'(`SHB_LCR_EIGHT_NONE_ONE & 8'h7F));
            chk(16'(hs_active[ch]), 16'h0001);
        end
        count_ticks;
        in_range(tick_cnt[0], fast_n - 3, fast_n + 3);
        in_range(tick_cnt[1], fast_n / 2 - 3, fast_n / 2 + 3);
        // locked data write must not move the device select
        wr(`SHB_CFG_DATA_PORT, `SHB_LDN_CH_A);
        wr(`SHB_CFG_INDEX_PORT, `SHB_KEY_ENTER);
        wr(`SHB_CFG_INDEX_PORT, `SHB_IDX_LDN);
        rd(`SHB_CFG_DATA_PORT, 8'h06);
        wr(`SHB_CFG_DATA_PORT, `SHB_LDN_CH_A);
        wr(`SHB_CFG_INDEX_PORT, `SHB_IDX_MODE);
        wr(`SHB_CFG_DATA_PORT, mode_v[0] & 8'hFD);
        wr(`SHB_CFG_INDEX_PORT, `SHB_KEY_EXIT);
        wr(base[1] + 16'h0003, 8'h80);
        wr(base[1], 8'h01);
        wr(base[1] + 16'h0001, 8'h00);
        wr(base[1] + 16'h0003, `SHB_LCR_EIGHT_NONE_ONE);
        settle;
        chk(16'(hs_active), 16'h0000);
        count_ticks;
        in_range(tick_cnt[0], 0, 1);
        in_range(tick_cnt[1], fast_n / 4 - 3, fast_n / 4 + 3);
        settle;
        chk(16'(exp_q.size()), 16'h0000);
        wrap_up;
    end
endmodule
